// file: design/lcs_consts.svh
/*
  offsets, field positions and reset values of the lane 3/4 source select register.
  assumes the includer uses these with the widths noted beside each.
*/
`ifndef LCS_CONSTS_SVH
`define LCS_CONSTS_SVH

// register offset on the plain register port
`define LCS_SEL34_OFFSET   4'h0
// field layout of lane34_source_select
`define LCS_FIELD_W        3
`define LCS_LANE3_LSB      0
`define LCS_LANE3_MSB      2
`define LCS_GAP3_BIT       3
`define LCS_LANE4_LSB      4
`define LCS_LANE4_MSB      6
`define LCS_GAP7_BIT       7
// value taken at power-on reset (contents undefined, zero chosen)
`define LCS_FIELD_RST      3'h0
`define LCS_RDATA_IDLE     8'h00
// number of shared input sources
`define LCS_SRC_N          8

`endif

// file: design/lcs_pkg.sv
/*
  types of the lane 3/4 source select block.
  assumes lcs_consts.svh is on the include path.
*/
`include "lcs_consts.svh"

package lcs_pkg;
  typedef logic [`LCS_FIELD_W-1:0] lcs_sel_t;
  typedef logic [7:0]              lcs_byte_t;
  typedef logic [`LCS_SRC_N-1:0]   lcs_src_t;
endpackage

// file: design/lcs_lane34_select.sv
/*
  lane 3 and lane 4 input source selector of the configurable logic cell,
  with its software register lane34_source_select.
  assumes a plain register port in the ref_clk_i domain, synchronous source
  inputs, and rst_b_i as the power-on / brown-out reset.
*/
// The implementer's own choices: the strobed register port and the placing of the registers.
`include "lcs_consts.svh"
`timescale 1ns/10ps
`default_nettype none

module lcs_lane34_select #(
  parameter int ADDR_W = 4,
  parameter int SRC_N  = `LCS_SRC_N
) (
  // clock and reset
  input  wire logic              ref_clk_i,
  input  wire logic              rst_b_i,
  // other resets, fields are kept across it
  input  wire logic              warm_rst_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire lcs_pkg::lcs_byte_t wr_data_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [7:0]             rd_data_o,
  // shared input sources
  input  wire lcs_pkg::lcs_src_t shared_input_source_i,
  // lanes toward the gate selection stage
  output logic                   data_lane_3_true_o,
  output logic                   data_lane_3_neg_o,
  output logic                   data_lane_4_true_o,
  output logic                   data_lane_4_neg_o
);

  if (SRC_N != (1 << `LCS_FIELD_W)) begin : g_bad_src_n
    $error("SRC_N must equal two to the field width");
  end
  if (ADDR_W < 4) begin : g_bad_addr_w
    $error("ADDR_W too narrow for the register offset");
  end

  // source picked by a select code
  function automatic logic pick_source(input lcs_pkg::lcs_src_t src, input lcs_pkg::lcs_sel_t sel);
    pick_source = src[sel];
  endfunction

  lcs_pkg::lcs_sel_t lane3_source_field_reg;
  lcs_pkg::lcs_sel_t lane3_source_field_next;
  lcs_pkg::lcs_sel_t lane4_source_field_reg;
  lcs_pkg::lcs_sel_t lane4_source_field_next;
  logic              hit;
  logic              wr_hit;
  lcs_pkg::lcs_byte_t sel34_view;
  logic              lane3_reg;
  logic              lane4_reg;
  lcs_pkg::lcs_byte_t rd_data_reg;

  assign hit    = (addr_i == ADDR_W'(`LCS_SEL34_OFFSET));
  assign wr_hit = wr_i && hit;

  // next field values from a write
  always_comb begin
    lane3_source_field_next = lane3_source_field_reg;
    lane4_source_field_next = lane4_source_field_reg;
    if (wr_hit) begin
      lane3_source_field_next = wr_data_i[`LCS_LANE3_MSB:`LCS_LANE3_LSB];
      lane4_source_field_next = wr_data_i[`LCS_LANE4_MSB:`LCS_LANE4_LSB];
    end
  end

  // select fields, only power-on reset touches them
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lane3_source_field_reg <= `LCS_FIELD_RST;
      lane4_source_field_reg <= `LCS_FIELD_RST;
    end else begin
      lane3_source_field_reg <= lane3_source_field_next;
      lane4_source_field_reg <= lane4_source_field_next;
    end
  end

  // register image, unimplemented bits tied low
  always_comb begin
    sel34_view                                    = `LCS_RDATA_IDLE;
    sel34_view[`LCS_LANE3_MSB:`LCS_LANE3_LSB] = lane3_source_field_reg;
    sel34_view[`LCS_LANE4_MSB:`LCS_LANE4_LSB] = lane4_source_field_reg;
  end

  // read data, valid only in the cycle after the read strobe
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_reg <= `LCS_RDATA_IDLE;
    end else if (rd_i && hit && !warm_rst_i) begin
      rd_data_reg <= sel34_view;
    end else begin
      rd_data_reg <= `LCS_RDATA_IDLE;
    end
  end

  // lane multiplexers, fed from the next field so a write acts at once
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lane3_reg <= 1'b0;
      lane4_reg <= 1'b0;
    end else begin
      lane3_reg <= pick_source(shared_input_source_i, lane3_source_field_next);
      lane4_reg <= pick_source(shared_input_source_i, lane4_source_field_next);
    end
  end

  assign rd_data_o          = rd_data_reg;
  assign data_lane_3_true_o = lane3_reg;
  assign data_lane_3_neg_o  = ~lane3_reg;
  assign data_lane_4_true_o = lane4_reg;
  assign data_lane_4_neg_o  = ~lane4_reg;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  chk_unimpl_bits_zero: assert property (
    rd_i |=> (rd_data_o[`LCS_GAP7_BIT] == 1'b0) && (rd_data_o[`LCS_GAP3_BIT] == 1'b0))
    else $error("unimplemented bit read as one");

  chk_lane4_mux_follow: assert property (
    1'b1 |=> data_lane_4_true_o == 1'(($past(shared_input_source_i) >> lane4_source_field_reg) & 8'h01))
    else $error("lane 4 not driven by selected source");

  chk_lane3_mux_follow: assert property (
    1'b1 |=> data_lane_3_true_o == 1'(($past(shared_input_source_i) >> lane3_source_field_reg) & 8'h01))
    else $error("lane 3 not driven by selected source");

  chk_write_read_back: assert property (
    wr_i && hit ##1 rd_i && hit && !warm_rst_i |=>
      rd_data_o == ($past(wr_data_i, 2) & 8'h77))
    else $error("read back differs from written fields");

  chk_fields_hold_quiet: assert property (
    !wr_i |=> $stable(lane3_source_field_reg) && $stable(lane4_source_field_reg))
    else $error("select field changed without a write");

  chk_true_neg_pair: assert property (
    (data_lane_3_neg_o == !data_lane_3_true_o) && (data_lane_4_neg_o == !data_lane_4_true_o))
    else $error("lane copies not complementary");

  chk_write_acts_now: assert property (
    wr_i && hit |=> data_lane_4_true_o ==
      1'(($past(shared_input_source_i) >> $past(wr_data_i[`LCS_LANE4_MSB:`LCS_LANE4_LSB])) & 8'h01))
    else $error("lane 4 did not switch on the write");

  chk_read_one_cycle: assert property (
    !rd_i |=> rd_data_o == `LCS_RDATA_IDLE)
    else $error("read data outside the answer cycle");

  cov_write_then_read: cover property (wr_i && hit ##1 rd_i && hit);
  cov_lane4_code7: cover property (wr_i && hit && wr_data_i[`LCS_LANE4_MSB:`LCS_LANE4_LSB] == 3'h7);
  cov_warm_reset_keep: cover property (warm_rst_i ##1 rd_i && hit);

endmodule

`default_nettype wire

// file: verification/lcs_gate_model.sv
/*
  model of gate one of the gate selection stage fed by lanes 3 and 4.
  assumes lane copies arrive settled from the selector.
*/
`timescale 1ns/10ps
`default_nettype none

module lcs_gate_model (
  // lanes from the selector
  input  wire logic       data_lane_3_true_i,
  input  wire logic       data_lane_3_neg_i,
  input  wire logic       data_lane_4_true_i,
  input  wire logic       data_lane_4_neg_i,
  // enables: lane4 true, lane4 neg, lane3 true, lane3 neg
  input  wire logic [3:0] gate_en_i,
  // gate output
  output logic            gate_one_input_o
);
  // true and inverted copies gated apart
  assign gate_one_input_o = |(gate_en_i & {data_lane_4_true_i, data_lane_4_neg_i,
                                           data_lane_3_true_i, data_lane_3_neg_i});
endmodule

`default_nettype wire

// file: verification/test_logic_cell_lane34_input_select.sv
/*
  self-checking bench of the lane 3/4 source selector.
  assumes the design package and the gate model are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none

module test_logic_cell_lane34_input_select;
  logic               clk = 0, rst_b = 0, warm = 0, wr = 0, rd = 0, g1;
  logic [3:0]         addr = 4'h0, gmask = 4'h0;
  lcs_pkg::lcs_byte_t wdata = 8'h00;
  lcs_pkg::lcs_src_t  src = 8'h00;
  logic [7:0]         rdata;
  logic               l3t, l3n, l4t, l4n;
  int                 errors = 0, checks_done = 0, cycles = 0;

  lcs_lane34_select dut (.ref_clk_i(clk), .rst_b_i(rst_b), .warm_rst_i(warm), .addr_i(addr),
    .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata), .shared_input_source_i(src),
    .data_lane_3_true_o(l3t), .data_lane_3_neg_o(l3n), .data_lane_4_true_o(l4t),
    .data_lane_4_neg_o(l4n));
  lcs_gate_model gm (.data_lane_3_true_i(l3t), .data_lane_3_neg_i(l3n), .data_lane_4_true_i(l4t),
    .data_lane_4_neg_i(l4n), .gate_en_i(gmask), .gate_one_input_o(g1));

  always #2.5 clk = ~clk;

  function automatic logic [3:0] lanes(input logic [7:0] s, input logic [7:0] f);
    return {s[f[6:4]], ~s[f[6:4]], s[f[2:0]], ~s[f[2:0]]};
  endfunction

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic end_of_test;
    if (errors == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      end_of_test();
    end
  end

  initial begin
    logic [7:0] d;
    void'($urandom(18));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(4'h0, 8'h00);
    for (int c = 0; c < 8; c++) begin
      src   <= 8'($urandom());
      gmask <= 4'($urandom());
      d = {1'b1, c[2:0], 1'b1, 3'(7 - c)};
      wr_reg(4'h0, d);
      #1;
      chk({4'h0, l4t, l4n, l3t, l3n}, {4'h0, lanes(src, d)});
      chk({7'h0, g1}, {7'h0, |(gmask & lanes(src, d))});
      rd_reg(4'h0, d & 8'h77);
    end
    // write straight followed by read, no gap
    d = 8'hff;
    @(posedge clk);
    addr  <= 4'h0;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, d & 8'h77);
    src <= ~src;
    @(posedge clk);
    #1;
    chk({4'h0, l4t, l4n, l3t, l3n}, {4'h0, lanes(src, d)});
    wr_reg(4'h5, 8'h00);
    rd_reg(4'h5, 8'h00);
    warm <= 1'b1;
    rd_reg(4'h0, 8'h00);
    warm <= 1'b0;
    rd_reg(4'h0, d & 8'h77);
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rd_reg(4'h0, 8'h00);
    end_of_test();
  end
endmodule

`default_nettype wire
